// File: pkg/cbf_params.svh
// Constants shared by the boot and fetch control ends.
`ifndef CBF_PARAMS_SVH
`define CBF_PARAMS_SVH

// Clock rate of clk_sys in MHz.
`define CBF_CLK_MHZ 20
// Least time that the core reset is held low after a reset request.
`define CBF_RESET_HOLD_NS 100
`define CBF_RESET_HOLD_CYC \
   ((`CBF_RESET_HOLD_NS * `CBF_CLK_MHZ + 999) / 1000)

// Registers of the integration controller, byte addresses on APB.
`define CBF_REG_CTRL 12'h000
`define CBF_REG_BOOT 12'h004
`define CBF_REG_TRAP 12'h008
`define CBF_REG_DBG_ENTRY 12'h00c
`define CBF_REG_DBG_FAULT 12'h010
`define CBF_REG_THREAD 12'h014
`define CBF_REG_STATUS 12'h018

// Control register fields.
`define CBF_CTRL_FETCH 0
`define CBF_CTRL_SCAN 1
`define CBF_CTRL_CLUSTER 2
`define CBF_CTRL_RESET 3
// Status register fields.
`define CBF_STAT_SLEEP 0
`define CBF_STAT_PERMIT 1
`define CBF_STAT_IN_RESET 2

// Reset values of the address registers.
`define CBF_BOOT_RESET 32'h0000_0080
`define CBF_TRAP_RESET 32'h0000_0000
`define CBF_DBG_ENTRY_RESET 32'h0000_0800
`define CBF_DBG_FAULT_RESET 32'h0000_0808
`define CBF_THREAD_RESET 32'h0000_0000

// Core CSR numbers seen on the core's read port.
`define CBF_CSR_MTVEC 12'h305
`define CBF_CSR_MHARTID 12'hf14
`define CBF_CSR_UHARTID 12'hcd0
`define CBF_CSR_CUSTOM_CFG 12'hcc8
`define CBF_CSR_PERF_BASE 12'hb03
// Upper bound of the performance counter option.
`define CBF_PERF_MAX 29

`endif

// File: pkg/cbf_pkg.sv
// Types shared by the boot and fetch control ends.
package cbf_pkg;
   typedef enum logic [1:0] {
      CBF_WAIT_PERMIT = 2'b00,
      CBF_RUNNING = 2'b01,
      CBF_SLEEPING = 2'b10
   } cbf_core_state_t;

   typedef enum logic [1:0] {
      CBF_HOLD_RESET = 2'b00,
      CBF_RELEASED = 2'b01,
      CBF_PERMITTED = 2'b10
   } cbf_host_state_t;
endpackage

// File: pkg/cbf_link_if.sv
// Static configuration and control wires between integrator and core.
interface cbf_link_if;
   logic reset_low_async;
   logic scan_gate_override;
   logic fetch_permit;
   logic cluster_clock_enable;
   logic core_sleeping;
   logic [31:0] boot_address;
   logic [31:0] trap_vector_address;
   logic [31:0] debug_entry_target;
   logic [31:0] debug_fault_target;
   logic [31:0] thread_identifier;

   modport device (
      input reset_low_async,
      input scan_gate_override,
      input fetch_permit,
      input cluster_clock_enable,
      output core_sleeping,
      input boot_address,
      input trap_vector_address,
      input debug_entry_target,
      input debug_fault_target,
      input thread_identifier
   );

   modport integrator (
      output reset_low_async,
      output scan_gate_override,
      output fetch_permit,
      output cluster_clock_enable,
      input core_sleeping,
      output boot_address,
      output trap_vector_address,
      output debug_entry_target,
      output debug_fault_target,
      output thread_identifier
   );
endinterface

// File: hdl/cbf_core_ctrl.sv
// Core end: fetch gating, boot and trap targets, CSRs, float pipes, sleep.
//
// Notes on behaviour
// [RL1] No first fetch while fetch permit is low.
// [RL2] Integrator holds fetch permit high outside reset while the fetch bit is set.
// [RL3] Once permitted, later fetch permit values are ignored.
// [RL4] First program counter equals the boot address.
// [RL5] Integrator keeps boot address half-word aligned.
// [RL6] Trap vector base starts from trap-vector input.
// [RL7] Debug entry jumps to word-aligned debug entry target.
// [RL8] Debug-mode exception jumps to word-aligned fault target.
// [RL9] Integrator freezes address inputs once fetching permitted.
// [RL10] Scan override opens every clock gate; functionally low.
// [RL11] Both thread identifier CSRs return the input value.
// [RL12] Cluster clock enable tied low without cluster support.
// [RL13] Float-in-integer-regs only with the float unit.
// [RL14] Float unit option adds float support, default absent.
// [RL15] Add-multiply stages set add/mul pipeline depth.
// [RL16] Misc stages set compare/convert/classify pipeline depth.
// [RL17] Custom option enables extensions and CSRs, not event-load.
// [RL18] Cluster option enables the event-load instruction.
// [RL19] Counter option sets number of performance counters.
// [RL20] Sleep output high while the core sleeps.
// [RL21] Permit state: async clear, set on first high sample.
//
// Implementation choices: the APB slave port and the register offsets.
`include "cbf_params.svh"
module cbf_core_ctrl #(
   parameter bit float_unit_enable = 1'b0,
   parameter int float_addmul_stages = 0,
   parameter int float_misc_stages = 0,
   parameter bit float_in_integer_regs = 1'b0,
   parameter bit custom_ext_enable = 1'b0,
   parameter bit cluster_support_enable = 1'b0,
   parameter int perf_counter_count = 1
) (
   input wire logic clk_sys,
   cbf_link_if.device link,
   output logic fetch_req,
   output logic [31:0] fetch_addr,
   input wire logic fetch_ack,
   input wire logic retire,
   input wire logic trap_taken,
   input wire logic debug_enter,
   input wire logic debug_fault,
   input wire logic debug_leave,
   output logic debug_mode,
   input wire logic sleep_request,
   input wire logic wake_event,
   output logic gate_open,
   input wire logic [11:0] csr_addr,
   output logic [31:0] csr_rdata,
   output logic csr_hit,
   input wire logic event_load_req,
   output logic event_load_ok,
   input wire logic float_op_valid,
   input wire logic float_op_misc,
   input wire logic [31:0] float_op_data,
   output logic float_res_valid,
   output logic [31:0] float_res_data,
   output logic float_uses_int_regs
);
   generate
      if (float_addmul_stages < 0 || float_misc_stages < 0) begin : g_bad_lat
         $error("Float pipeline depths must not be negative.");
      end
      if (perf_counter_count < 0 || perf_counter_count > `CBF_PERF_MAX) begin : g_bad_cnt
         $error("Performance counter count out of range.");
      end
      if (float_in_integer_regs && !float_unit_enable) begin : g_bad_fin
         $error("Float in integer registers needs the float unit."); // RL13
      end
   endgenerate

   cbf_pkg::cbf_core_state_t state;
   cbf_pkg::cbf_core_state_t next_state;
   logic [31:0] pc;
   logic [31:0] next_pc;
   logic [31:0] trap_base;
   logic next_debug_mode;

   wire logic waiting = (state == cbf_pkg::CBF_WAIT_PERMIT);
   wire logic running = (state == cbf_pkg::CBF_RUNNING);
   wire logic sleeping = (state == cbf_pkg::CBF_SLEEPING);
   wire logic fault_in_debug = debug_mode && debug_fault;

   // The permit input is looked at only while waiting, so a later low
   // level cannot stop a running core.
   always_comb begin
      next_state = state;
      unique case (state)
         cbf_pkg::CBF_WAIT_PERMIT: begin
            if (link.fetch_permit) begin // RL21
               next_state = cbf_pkg::CBF_RUNNING; // RL3
            end
         end
         cbf_pkg::CBF_RUNNING: begin
            if (sleep_request && !debug_mode) begin
               next_state = cbf_pkg::CBF_SLEEPING;
            end
         end
         cbf_pkg::CBF_SLEEPING: begin
            if (wake_event || debug_enter) begin
               next_state = cbf_pkg::CBF_RUNNING;
            end
         end
         default: next_state = cbf_pkg::CBF_WAIT_PERMIT;
      endcase
   end

   // Redirects take priority over sequential fetch; the debug targets
   // are used with their low bits as given, the integrator aligns them.
   always_comb begin
      next_pc = pc;
      if (waiting) begin
         next_pc = link.boot_address; // RL4
      end else if (fault_in_debug) begin
         next_pc = link.debug_fault_target; // RL8
      end else if (debug_enter && !debug_mode) begin
         next_pc = link.debug_entry_target; // RL7
      end else if (trap_taken && !debug_mode) begin
         next_pc = trap_base;
      end else if (fetch_req && fetch_ack) begin
         next_pc = pc + 32'h0000_0004;
      end
   end

   always_comb begin
      next_debug_mode = debug_mode;
      if (debug_enter && !waiting) begin
         next_debug_mode = 1'b1;
      end else if (debug_leave) begin
         next_debug_mode = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge link.reset_low_async) begin
      if (!link.reset_low_async) begin
         state <= cbf_pkg::CBF_WAIT_PERMIT; // RL21
         pc <= 32'h0000_0000;
         debug_mode <= 1'b0;
      end else begin
         state <= next_state;
         pc <= next_pc;
         debug_mode <= next_debug_mode;
      end
   end

   // The base is reloaded while waiting so it is current at the first fetch.
   always_ff @(posedge clk_sys or negedge link.reset_low_async) begin
      if (!link.reset_low_async) begin
         trap_base <= 32'h0000_0000;
      end else if (waiting) begin
         trap_base <= {link.trap_vector_address[31:2], 2'b00}; // RL6
      end
   end

   assign fetch_req = running; // RL1
   assign fetch_addr = pc;
   assign link.core_sleeping = sleeping; // RL20
   // A sleeping core may keep its gate open for the cluster or for scan override.
   wire logic cluster_keep = cluster_support_enable && link.cluster_clock_enable;
   assign gate_open = !sleeping || cluster_keep || link.scan_gate_override; // RL10
   assign event_load_ok = cluster_support_enable && event_load_req && running; // RL18
   assign float_uses_int_regs = float_unit_enable && float_in_integer_regs;

   // Float pipes: one delay chain per operation class, depth from the option.
   logic [1:0] lane_valid;
   logic [31:0] lane_data [2];
   for (genvar c = 0; c < 2; c++) begin : g_lane
      localparam int LAT = (c == 0) ? float_addmul_stages : float_misc_stages;
      logic [LAT:0] v;
      logic [31:0] d [LAT+1];
      assign v[0] = float_unit_enable && float_op_valid
         && (float_op_misc == (c == 1)); // RL14
      assign d[0] = float_op_data;
      for (genvar s = 0; s < LAT; s++) begin : g_stage
         always_ff @(posedge clk_sys or negedge link.reset_low_async) begin
            if (!link.reset_low_async) begin
               v[s+1] <= 1'b0;
               d[s+1] <= 32'h0000_0000;
            end else begin
               v[s+1] <= v[s]; // RL15 RL16
               d[s+1] <= d[s];
            end
         end
      end
      assign lane_valid[c] = v[LAT];
      assign lane_data[c] = d[LAT];
   end
   assign float_res_valid = |lane_valid;
   assign float_res_data = lane_valid[1] ? lane_data[1] : lane_data[0];

   // Performance counters: counter 0 counts open-gate cycles, the rest
   // count retired instructions.
   localparam int NCNT = (perf_counter_count > 0) ? perf_counter_count : 1;
   logic [31:0] perf [NCNT];
   for (genvar i = 0; i < NCNT; i++) begin : g_perf
      wire logic bump = (i == 0) ? gate_open : retire;
      always_ff @(posedge clk_sys or negedge link.reset_low_async) begin
         if (!link.reset_low_async) begin
            perf[i] <= 32'h0000_0000;
         end else if (bump && i < perf_counter_count) begin // RL19
            perf[i] <= perf[i] + 32'h0000_0001;
         end
      end
   end

   wire logic is_thread_csr = (csr_addr == `CBF_CSR_MHARTID)
      || (csr_addr == `CBF_CSR_UHARTID);
   wire logic is_custom_csr = custom_ext_enable
      && (csr_addr == `CBF_CSR_CUSTOM_CFG); // RL17
   wire logic [31:0] custom_cfg = {24'h00_0000,
      1'b0, float_uses_int_regs, float_unit_enable,
      cluster_support_enable, custom_ext_enable, 3'h0};

   always_comb begin
      csr_rdata = 32'h0000_0000;
      csr_hit = 1'b0;
      if (is_thread_csr) begin
         csr_rdata = link.thread_identifier; // RL11
         csr_hit = 1'b1;
      end else if (csr_addr == `CBF_CSR_MTVEC) begin
         csr_rdata = trap_base;
         csr_hit = 1'b1;
      end else if (is_custom_csr) begin
         csr_rdata = custom_cfg;
         csr_hit = 1'b1;
      end
      for (int i = 0; i < perf_counter_count; i++) begin
         if (csr_addr == `CBF_CSR_PERF_BASE + 12'(i)) begin
            csr_rdata = perf[i];
            csr_hit = 1'b1;
         end
      end
   end
endmodule

// File: hdl/cbf_integrator.sv
// Integrator end: APB registers that drive the core's static configuration.
`include "cbf_params.svh"
module cbf_integrator #(
   parameter bit float_unit_enable = 1'b0,
   parameter bit float_in_integer_regs = 1'b0,
   parameter bit cluster_support_enable = 1'b0
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   cbf_link_if.integrator link
);
   generate
      if (float_in_integer_regs && !float_unit_enable) begin : g_bad_fin
         $error("Float in integer registers needs the float unit."); // RL13
      end
   endgenerate

   localparam int HOLD = (`CBF_RESET_HOLD_CYC < 1) ? 1 : `CBF_RESET_HOLD_CYC;
   cbf_pkg::cbf_host_state_t state;
   logic [7:0] hold_cnt;
   logic [3:0] ctrl;
   logic [31:0] boot, trap, dbg_entry, dbg_fault, thread;

   wire logic wr = psel && penable && pwrite;
   wire logic hit_ctrl = (paddr == `CBF_REG_CTRL);
   wire logic hit_boot = (paddr == `CBF_REG_BOOT);
   wire logic hit_trap = (paddr == `CBF_REG_TRAP);
   wire logic hit_entry = (paddr == `CBF_REG_DBG_ENTRY);
   wire logic hit_fault = (paddr == `CBF_REG_DBG_FAULT);
   wire logic hit_thread = (paddr == `CBF_REG_THREAD);
   wire logic hit_status = (paddr == `CBF_REG_STATUS);
   wire logic mapped = hit_ctrl || hit_boot || hit_trap || hit_entry
      || hit_fault || hit_thread || hit_status;
   wire logic soft_reset = wr && hit_ctrl && pwdata[`CBF_CTRL_RESET];
   // Addresses are frozen from the permit until the next core reset.
   wire logic addr_open = (state != cbf_pkg::CBF_PERMITTED); // RL9
   wire logic wr_addr = wr && addr_open;
   wire logic [31:0] status = {29'h0000_0000,
      (state == cbf_pkg::CBF_HOLD_RESET),
      (state == cbf_pkg::CBF_PERMITTED), link.core_sleeping};

   always_ff @(posedge clk_sys) begin
      if (reset || soft_reset) begin
         state <= cbf_pkg::CBF_HOLD_RESET;
         hold_cnt <= 8'h00;
      end else begin
         unique case (state)
            cbf_pkg::CBF_HOLD_RESET: begin
               hold_cnt <= hold_cnt + 8'h01;
               if (hold_cnt == 8'(HOLD - 1)) begin
                  state <= cbf_pkg::CBF_RELEASED;
               end
            end
            cbf_pkg::CBF_RELEASED: begin
               if (ctrl[`CBF_CTRL_FETCH]) begin
                  state <= cbf_pkg::CBF_PERMITTED;
               end
            end
            cbf_pkg::CBF_PERMITTED: state <= cbf_pkg::CBF_PERMITTED;
            default: state <= cbf_pkg::CBF_HOLD_RESET;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ctrl <= 4'h0;
      end else if (wr && hit_ctrl) begin
         ctrl <= {1'b0, pwdata[2:0]};
      end
   end

   // Low bits are forced to zero so the alignment demands always hold.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         boot <= `CBF_BOOT_RESET;
         trap <= `CBF_TRAP_RESET;
         dbg_entry <= `CBF_DBG_ENTRY_RESET;
         dbg_fault <= `CBF_DBG_FAULT_RESET;
         thread <= `CBF_THREAD_RESET;
      end else begin
         if (wr_addr && hit_boot) begin
            boot <= {pwdata[31:1], 1'b0}; // RL5
         end
         if (wr_addr && hit_trap) begin
            trap <= pwdata;
         end
         if (wr_addr && hit_entry) begin
            dbg_entry <= {pwdata[31:2], 2'b00}; // RL7
         end
         if (wr_addr && hit_fault) begin
            dbg_fault <= {pwdata[31:2], 2'b00}; // RL8
         end
         if (wr_addr && hit_thread) begin
            thread <= pwdata;
         end
      end
   end

   assign link.reset_low_async = (state != cbf_pkg::CBF_HOLD_RESET);
   // Permit is only driven outside reset, held at least one cycle.
   assign link.fetch_permit = (state != cbf_pkg::CBF_HOLD_RESET)
      && ctrl[`CBF_CTRL_FETCH]; // RL2
   assign link.scan_gate_override = ctrl[`CBF_CTRL_SCAN]; // RL10
   assign link.cluster_clock_enable = cluster_support_enable
      && ctrl[`CBF_CTRL_CLUSTER]; // RL12
   assign link.boot_address = boot;
   assign link.trap_vector_address = trap;
   assign link.debug_entry_target = dbg_entry;
   assign link.debug_fault_target = dbg_fault;
   assign link.thread_identifier = thread;

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   always_comb begin
      prdata = 32'h0000_0000;
      if (hit_ctrl) prdata = {28'h000_0000, ctrl};
      if (hit_boot) prdata = boot;
      if (hit_trap) prdata = trap;
      if (hit_entry) prdata = dbg_entry;
      if (hit_fault) prdata = dbg_fault;
      if (hit_thread) prdata = thread;
      if (hit_status) prdata = status;
   end
endmodule

// File: dv/cbf_link_properties.sv
// Properties of the link between integrator and core, with core outputs.
`include "cbf_params.svh"
module cbf_link_props #(
   parameter bit cluster_support_enable = 1'b0
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic reset_low_async,
   input wire logic scan_gate_override,
   input wire logic fetch_permit,
   input wire logic cluster_clock_enable,
   input wire logic core_sleeping,
   input wire logic [31:0] boot_address,
   input wire logic [31:0] trap_vector_address,
   input wire logic [31:0] debug_entry_target,
   input wire logic [31:0] debug_fault_target,
   input wire logic [31:0] thread_identifier,
   input wire logic fetch_req,
   input wire logic [31:0] fetch_addr,
   input wire logic debug_enter,
   input wire logic debug_mode,
   input wire logic gate_open,
   input wire logic [11:0] csr_addr,
   input wire logic [31:0] csr_rdata,
   input wire logic csr_hit
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset || !reset_low_async);

   a_fetch_gated: assert property (
      !fetch_req && !fetch_permit && !core_sleeping |=> !fetch_req)
      else $error("fetch started without permit");
   a_first_pc: assert property (
      $rose(fetch_req) && !$past(core_sleeping)
      |-> fetch_addr == boot_address)
      else $error("first fetch address differs from boot address");
   a_permit_ignored: assert property (
      fetch_req && !fetch_permit |=> fetch_req || core_sleeping)
      else $error("fetching stopped when permit fell");
   a_permit_outside_reset: assert property (disable iff (reset)
      fetch_permit |-> reset_low_async)
      else $error("permit raised while core held in reset");
   a_reset_hold: assert property (disable iff (reset)
      $fell(reset) |-> !reset_low_async ##[1:4] reset_low_async)
      else $error("core reset not released after hold");
   a_sleep_stops: assert property (core_sleeping |-> !fetch_req)
      else $error("fetching while sleeping");
   a_thread_csr: assert property (
      csr_addr == `CBF_CSR_MHARTID || csr_addr == `CBF_CSR_UHARTID
      |-> csr_hit && csr_rdata == thread_identifier)
      else $error("thread identifier read wrong");
   a_trap_csr: assert property (
      csr_addr == `CBF_CSR_MTVEC
      |-> csr_rdata == {trap_vector_address[31:2], 2'b00})
      else $error("trap vector base read wrong");
   a_debug_entry: assert property (
      debug_enter && fetch_req
      |=> debug_mode && fetch_addr == debug_entry_target)
      else $error("debug entry did not jump to entry target");
   a_scan_gate: assert property (scan_gate_override |-> gate_open)
      else $error("scan override did not open the gate");
   a_cluster_tied: assert property (disable iff (reset)
      !cluster_support_enable |-> !cluster_clock_enable)
      else $error("cluster clock enable driven without cluster option");
   a_addr_aligned: assert property (disable iff (reset)
      !boot_address[0] && debug_entry_target[1:0] == 2'b00
      && debug_fault_target[1:0] == 2'b00)
      else $error("misaligned configuration address");

   c_first_fetch: cover property ($rose(fetch_req));
   c_sleep: cover property ($rose(core_sleeping));
   c_debug: cover property ($rose(debug_mode));
endmodule

// File: dv/cbf_testbench.sv
// Bench joining the integrator and core ends through the link interface.
`include "cbf_params.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] q;
      logic e;
   } cbf_row_t;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, fetch_addr, csr_rdata, float_res_data, rd;
   logic pready, pslverr, fetch_req, debug_mode, gate_open, csr_hit, e;
   logic event_load_ok, float_res_valid, float_uses_int_regs;
   // Pulse bits: ack, retire, trap, enter, fault, leave, sleep, wake.
   logic [7:0] ctl = 8'h00;
   logic [11:0] csr_addr = 12'h000;
   logic event_load_req = 1'b0;
   logic float_op_valid = 1'b0;
   logic float_op_misc = 1'b0;
   logic [31:0] float_op_data = 32'h0;
   int n_fail = 0;
   int comparisons = 0;
   int k;
   cbf_row_t rows [6] = '{
      '{`CBF_REG_BOOT, 32'h0000_1235, 32'h0000_1234, 1'b0},
      '{`CBF_REG_TRAP, 32'h0000_4001, 32'h0000_4001, 1'b0},
      '{`CBF_REG_DBG_ENTRY, 32'h0000_2003, 32'h0000_2000, 1'b0},
      '{`CBF_REG_DBG_FAULT, 32'h0000_3006, 32'h0000_3004, 1'b0},
      '{`CBF_REG_THREAD, 32'h0000_abcd, 32'h0000_abcd, 1'b0},
      '{12'h01c, 32'h0000_0005, 32'h0000_0000, 1'b1}};
   logic [43:0] rv [5] = '{{`CBF_REG_BOOT, `CBF_BOOT_RESET},
      {`CBF_REG_TRAP, `CBF_TRAP_RESET},
      {`CBF_REG_DBG_ENTRY, `CBF_DBG_ENTRY_RESET},
      {`CBF_REG_DBG_FAULT, `CBF_DBG_FAULT_RESET},
      {`CBF_REG_THREAD, `CBF_THREAD_RESET}};

   cbf_link_if link ();
   always #25 clk_sys = ~clk_sys;

   cbf_integrator cbf_integrator_i (.clk_sys(clk_sys), .reset(reset),
      .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
   cbf_core_ctrl #(
      .float_unit_enable(1'b1),
      .float_addmul_stages(2),
      .float_misc_stages(1),
      .float_in_integer_regs(1'b1),
      .custom_ext_enable(1'b1)
   ) cbf_core_ctrl_i (.clk_sys(clk_sys), .link(link),
      .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(ctl[0]),
      .retire(ctl[1]), .trap_taken(ctl[2]), .debug_enter(ctl[3]),
      .debug_fault(ctl[4]), .debug_leave(ctl[5]), .debug_mode(debug_mode),
      .sleep_request(ctl[6]), .wake_event(ctl[7]), .gate_open(gate_open),
      .csr_addr(csr_addr), .csr_rdata(csr_rdata), .csr_hit(csr_hit),
      .event_load_req(event_load_req), .event_load_ok(event_load_ok),
      .float_op_valid(float_op_valid), .float_op_misc(float_op_misc),
      .float_op_data(float_op_data), .float_res_valid(float_res_valid),
      .float_res_data(float_res_data),
      .float_uses_int_regs(float_uses_int_regs));
   cbf_link_props cbf_link_props_i (
      .clk_sys(clk_sys), .reset(reset),
      .reset_low_async(link.reset_low_async),
      .scan_gate_override(link.scan_gate_override),
      .fetch_permit(link.fetch_permit),
      .cluster_clock_enable(link.cluster_clock_enable),
      .core_sleeping(link.core_sleeping), .boot_address(link.boot_address),
      .trap_vector_address(link.trap_vector_address),
      .debug_entry_target(link.debug_entry_target),
      .debug_fault_target(link.debug_fault_target),
      .thread_identifier(link.thread_identifier), .fetch_req(fetch_req),
      .fetch_addr(fetch_addr), .debug_enter(ctl[3]),
      .debug_mode(debug_mode), .gate_open(gate_open), .csr_addr(csr_addr),
      .csr_rdata(csr_rdata), .csr_hit(csr_hit));

   task automatic summarize();
      if (n_fail == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic probe(input int s);
      case (s)
         0: return fetch_req;
         1: return link.reset_low_async;
         default: return float_res_valid;
      endcase
   endfunction

   // Counts settled edges until the chosen flag is high; a hang ends the run.
   task automatic wait_hi(input int s, output int n);
      n = 0;
      while (probe(s) !== 1'b1 && n < 40) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n >= 40) begin
         chk(32'h0, 32'h1);
         summarize();
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic er);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) begin
         chk(32'h0, 32'h1);
         summarize();
      end
      q = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   task automatic pulse(input int b);
      @(posedge clk_sys);
      ctl[b] <= 1'b1;
      @(posedge clk_sys);
      ctl[b] <= 1'b0;
      #1;
   endtask

   task automatic rdcsr(input logic [11:0] a);
      @(posedge clk_sys);
      csr_addr <= a;
      #1;
   endtask

   initial begin
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      wait_hi(1, k);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d, rd, e);
         apb(1'b0, rows[i].a, 32'h0, rd, e);
         chk(rd, rows[i].q);
         chk({31'h0, e}, {31'h0, rows[i].e});
      end
      rdcsr(`CBF_CSR_MTVEC);
      chk(csr_rdata, 32'h0000_4000);
      rdcsr(`CBF_CSR_MHARTID);
      chk(csr_rdata, 32'h0000_abcd);
      rdcsr(`CBF_CSR_UHARTID);
      chk(csr_rdata, 32'h0000_abcd);
      repeat (4) @(posedge clk_sys);
      chk({31'h0, fetch_req}, 32'h0);
      apb(1'b1, `CBF_REG_CTRL, 32'h1, rd, e);
      wait_hi(0, k);
      chk(fetch_addr, 32'h0000_1234);
      apb(1'b1, `CBF_REG_CTRL, 32'h0, rd, e);
      apb(1'b1, `CBF_REG_BOOT, 32'h0000_8888, rd, e);
      apb(1'b0, `CBF_REG_BOOT, 32'h0, rd, e);
      chk(rd, 32'h0000_1234);
      chk({31'h0, fetch_req}, 32'h1);
      pulse(0);
      chk(fetch_addr, 32'h0000_1238);
      pulse(2);
      chk(fetch_addr, 32'h0000_4000);
      pulse(3);
      chk({debug_mode, fetch_addr[30:0]}, 32'h8000_2000);
      pulse(4);
      chk(fetch_addr, 32'h0000_3004);
      pulse(5);
      chk({31'h0, debug_mode}, 32'h0);
      pulse(6);
      chk({29'h0, fetch_req, link.core_sleeping, gate_open}, 32'h2);
      apb(1'b0, `CBF_REG_STATUS, 32'h0, rd, e);
      chk(rd, 32'h0000_0003);
      apb(1'b1, `CBF_REG_CTRL, 32'h2, rd, e);
      chk({31'h0, gate_open}, 32'h1);
      apb(1'b1, `CBF_REG_CTRL, 32'h4, rd, e);
      chk({30'h0, gate_open, link.cluster_clock_enable}, 32'h0);
      pulse(7);
      chk({30'h0, fetch_req, link.core_sleeping}, 32'h2);
      rdcsr(`CBF_CSR_PERF_BASE);
      rd = csr_rdata;
      pulse(1);
      chk(csr_rdata, rd + 32'h2);
      chk({31'h0, csr_hit}, 32'h1);
      rdcsr(`CBF_CSR_PERF_BASE + 12'h001);
      chk({31'h0, csr_hit}, 32'h0);
      rdcsr(`CBF_CSR_CUSTOM_CFG);
      chk(csr_rdata & 32'h78, 32'h68);
      @(posedge clk_sys);
      event_load_req <= 1'b1;
      #1;
      chk({30'h0, event_load_ok, float_uses_int_regs}, 32'h1);
      for (int m = 0; m < 2; m++) begin
         @(posedge clk_sys);
         float_op_valid <= 1'b1;
         float_op_misc <= m[0];
         float_op_data <= 32'h0000_1357 + m;
         @(posedge clk_sys);
         float_op_valid <= 1'b0;
         #1;
         wait_hi(2, k);
         chk(k, 1 - m);
         chk(float_res_data, 32'h0000_1357 + m);
      end
      apb(1'b1, `CBF_REG_CTRL, 32'h8, rd, e);
      chk({30'h0, fetch_req, link.reset_low_async}, 32'h0);
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      wait_hi(1, k);
      chk({31'h0, fetch_req}, 32'h0);
      foreach (rv[i]) begin
         apb(1'b0, rv[i][43:32], 32'h0, rd, e);
         chk(rd, rv[i][31:0]);
      end
      summarize();
   end
endmodule
